// ---- design/tsm_test_signal_output_mux.v ----
// Test signal output multiplexer for the channel clear and frame start pins, with APB registers.
`timescale 1ns/1ps
`include "tsm_regs.vh"
// How it works
// - Select zero passes the pin's normal function.
// - First pin, select 2: late resync pulse.
// - Second pin, select 2: early resync pulse.
// - First pin, select 12: gain change pulse.
// - Select 3 shows synthesizer lock flag.
// - First pin 4/5: modulator chip, bit clocks.
// - Second pin 4/5: modulator chip, bit streams.
// - Selects 6 to 11: power-down controls.
// - Select 1: converter LSB, Q first, I second.
// - First pin 23: eight meg clock; second reserved.
// - First pin 24: crystal stable flag.
// - Selects 25, 26: synth reference, divided signals.
// - Selects 27, 28: lock window, synchronised window.
// - Peak detector stages on selects 12 to 14; first pin only on 13 and 14.
// - Selects 15, 16: gain mode, VGA gain bits.
// - Select 17: peak reset or filter clock.
// - 24 comparator, 29 converter clocks, 30/31 constants.
module tsm_test_signal_output_mux (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire channel_clear_in,
   input wire frame_start_in,
   input wire adc_q_lsb,
   input wire adc_i_lsb,
   input wire demod_late_pulse,
   input wire demod_early_pulse,
   input wire gain_change_pulse,
   input wire synth_lock_flag,
   input wire modulator_chip_rate_clock,
   input wire modulator_bit_rate_clock,
   input wire modulator_chip_stream,
   input wire modulator_bit_stream,
   input wire [5:0] power_down_controls,
   input wire [4:0] vga_peak_detect,
   input wire [1:0] frontend_gain_mode,
   input wire [1:0] vga_gain,
   input wire peak_reset_n,
   input wire rx_filter_calibration_clock,
   input wire eight_meg_clock_in,
   input wire crystal_stable_flag,
   input wire synth_reference_signal,
   input wire synth_divided_signal,
   input wire synth_lock_window,
   input wire synth_lock_window_sync,
   input wire synth_freq_comparator_out,
   input wire converter_clock_one,
   input wire converter_clock_two,
   output reg channel_clear_pin,
   output reg frame_start_pin,
   output reg eight_meg_clock_out
);
   reg [4:0] first_pin_test_select;
   reg [4:0] second_pin_test_select;
   reg [4:0] next_first_pin_test_select;
   reg [4:0] next_second_pin_test_select;
   reg next_channel_clear_pin;
   reg next_frame_start_pin;
   reg next_eight_meg_clock_out;
   reg [31:0] next_prdata;
   reg next_pready;
   reg next_pslverr;
   wire common_first;
   wire common_second;
   wire apb_access;
   wire apb_first_cycle;
   wire apb_handshake;
   wire apb_write;
   wire apb_read;
   wire config_hit;
   wire status_hit;
   wire addr_hit;

   // Signals shared by both pins; returns low for codes it does not own.
   function common_sel;
      input [4:0] sel;
      input lock;
      input [5:0] pd;
      input ref_sig;
      input div_sig;
      input win;
      input win_sync;
      begin
         case (sel)
            `TSM_SEL_LOCK: common_sel = lock;
            `TSM_SEL_PD_SYNTH: common_sel = pd[0];
            `TSM_SEL_PD_CONV: common_sel = pd[1];
            `TSM_SEL_PD_VGA: common_sel = pd[2];
            `TSM_SEL_PD_BPF: common_sel = pd[3];
            `TSM_SEL_PD_LNA: common_sel = pd[4];
            `TSM_SEL_PD_PA: common_sel = pd[5];
            `TSM_SEL_REF: common_sel = ref_sig;
            `TSM_SEL_DIV: common_sel = div_sig;
            `TSM_SEL_WIN: common_sel = win;
            `TSM_SEL_WIN_SYNC: common_sel = win_sync;
            `TSM_SEL_ONE: common_sel = 1'b1;
            default: common_sel = 1'b0;
         endcase
      end
   endfunction

   // Read-back image of the configuration register; unused bits read as zero.
   function [31:0] config_word;
      input [4:0] first_sel;
      input [4:0] second_sel;
      begin
         config_word = 32'h00000000;
         config_word[`TSM_FIRST_SEL_LSB +: `TSM_SEL_WIDTH] = first_sel;
         config_word[`TSM_SECOND_SEL_LSB +: `TSM_SEL_WIDTH] = second_sel;
      end
   endfunction

   // Read-back image of the status register.
   function [31:0] status_word;
      input clear_pin;
      input start_pin;
      input lock;
      input xtal_stable;
      begin
         status_word = 32'h00000000;
         status_word[0] = clear_pin;
         status_word[1] = start_pin;
         status_word[2] = lock;
         status_word[3] = xtal_stable;
      end
   endfunction

   assign apb_access = psel & penable;
   assign apb_first_cycle = apb_access & ~pready;
   assign apb_handshake = apb_access & pready;
   assign apb_write = apb_handshake & pwrite;
   assign apb_read = apb_first_cycle & ~pwrite;
   assign config_hit = (paddr == `TSM_PIN_CONFIG_OFFSET);
   assign status_hit = (paddr == `TSM_STATUS_OFFSET);
   assign addr_hit = config_hit | status_hit;

   assign common_first = common_sel(
      first_pin_test_select,
      synth_lock_flag,
      power_down_controls,
      synth_reference_signal,
      synth_divided_signal,
      synth_lock_window,
      synth_lock_window_sync);
   assign common_second = common_sel(
      second_pin_test_select,
      synth_lock_flag,
      power_down_controls,
      synth_reference_signal,
      synth_divided_signal,
      synth_lock_window,
      synth_lock_window_sync);

   // One wait state: pready rises after the first access cycle and falls after the handshake,
   // so read data is captured once and stands while pready is high.
   always @* begin
      next_pready = apb_first_cycle;
      next_pslverr = apb_first_cycle & ~addr_hit;
      next_prdata = prdata;
      if (apb_read) begin
         if (config_hit) begin
            next_prdata = config_word(first_pin_test_select, second_pin_test_select);
         end else if (status_hit) begin
            next_prdata = status_word(channel_clear_pin, frame_start_pin, synth_lock_flag,
               crystal_stable_flag);
         end else begin
            next_prdata = 32'h00000000;
         end
      end
   end

   // A write lands at the handshake edge, the one at which the master samples pready high.
   always @* begin
      next_first_pin_test_select = first_pin_test_select;
      next_second_pin_test_select = second_pin_test_select;
      if (apb_write && config_hit) begin
         next_first_pin_test_select = pwdata[`TSM_FIRST_SEL_LSB +: `TSM_SEL_WIDTH];
         next_second_pin_test_select = pwdata[`TSM_SECOND_SEL_LSB +: `TSM_SEL_WIDTH];
      end
   end

   // Pulse inputs share the clock and pass one register, so a one-cycle pulse stays one wide.
   always @* begin
      next_eight_meg_clock_out = 1'b0;
      case (first_pin_test_select)
         `TSM_SEL_NORMAL: begin
            next_channel_clear_pin = channel_clear_in;
         end
         `TSM_SEL_ADC_LSB: begin
            next_channel_clear_pin = adc_q_lsb;
         end
         `TSM_SEL_PULSE: begin
            next_channel_clear_pin = demod_late_pulse;
         end
         `TSM_SEL_MOD_A: begin
            next_channel_clear_pin = modulator_chip_rate_clock;
         end
         `TSM_SEL_MOD_B: begin
            next_channel_clear_pin = modulator_bit_rate_clock;
         end
         `TSM_SEL_12: begin
            next_channel_clear_pin = gain_change_pulse;
         end
         `TSM_SEL_13: begin
            next_channel_clear_pin = vga_peak_detect[1];
         end
         `TSM_SEL_14: begin
            next_channel_clear_pin = vga_peak_detect[3];
         end
         `TSM_SEL_GAINMODE: begin
            next_channel_clear_pin = frontend_gain_mode[1];
         end
         `TSM_SEL_VGA_GAIN: begin
            next_channel_clear_pin = vga_gain[1];
         end
         `TSM_SEL_17: begin
            next_channel_clear_pin = peak_reset_n;
         end
         5'h12: begin
            next_channel_clear_pin = 1'b0;
         end
         5'h13: begin
            next_channel_clear_pin = 1'b0;
         end
         5'h14: begin
            next_channel_clear_pin = 1'b0;
         end
         5'h15: begin
            next_channel_clear_pin = 1'b0;
         end
         5'h16: begin
            next_channel_clear_pin = 1'b0;
         end
         `TSM_SEL_23: begin
            next_channel_clear_pin = eight_meg_clock_in;
            next_eight_meg_clock_out = eight_meg_clock_in;
         end
         `TSM_SEL_24: begin
            next_channel_clear_pin = crystal_stable_flag;
         end
         `TSM_SEL_CONV_CLK: begin
            next_channel_clear_pin = converter_clock_one;
         end
         default: begin
            next_channel_clear_pin = common_first;
         end
      endcase
   end

   always @* begin
      case (second_pin_test_select)
         `TSM_SEL_NORMAL: begin
            next_frame_start_pin = frame_start_in;
         end
         `TSM_SEL_ADC_LSB: begin
            next_frame_start_pin = adc_i_lsb;
         end
         `TSM_SEL_PULSE: begin
            next_frame_start_pin = demod_early_pulse;
         end
         `TSM_SEL_MOD_A: begin
            next_frame_start_pin = modulator_chip_stream;
         end
         `TSM_SEL_MOD_B: begin
            next_frame_start_pin = modulator_bit_stream;
         end
         `TSM_SEL_12: begin
            next_frame_start_pin = vga_peak_detect[0];
         end
         `TSM_SEL_13: begin
            next_frame_start_pin = vga_peak_detect[2];
         end
         `TSM_SEL_14: begin
            next_frame_start_pin = vga_peak_detect[4];
         end
         `TSM_SEL_GAINMODE: begin
            next_frame_start_pin = frontend_gain_mode[0];
         end
         `TSM_SEL_VGA_GAIN: begin
            next_frame_start_pin = vga_gain[0];
         end
         `TSM_SEL_17: begin
            next_frame_start_pin = rx_filter_calibration_clock;
         end
         5'h12: begin
            next_frame_start_pin = 1'b0;
         end
         5'h13: begin
            next_frame_start_pin = 1'b0;
         end
         5'h14: begin
            next_frame_start_pin = 1'b0;
         end
         5'h15: begin
            next_frame_start_pin = 1'b0;
         end
         5'h16: begin
            next_frame_start_pin = 1'b0;
         end
         `TSM_SEL_23: begin
            next_frame_start_pin = 1'b0;
         end
         `TSM_SEL_24: begin
            next_frame_start_pin = synth_freq_comparator_out;
         end
         `TSM_SEL_CONV_CLK: begin
            next_frame_start_pin = converter_clock_two;
         end
         default: begin
            next_frame_start_pin = common_second;
         end
      endcase
   end

   // Both selects leave reset at zero, so the pins start with their normal functions.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_pin_test_select <= `TSM_SEL_NORMAL;
         second_pin_test_select <= `TSM_SEL_NORMAL;
      end else begin
         first_pin_test_select <= next_first_pin_test_select;
         second_pin_test_select <= next_second_pin_test_select;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_clear_pin <= 1'b0;
         frame_start_pin <= 1'b0;
         eight_meg_clock_out <= 1'b0;
      end else begin
         channel_clear_pin <= next_channel_clear_pin;
         frame_start_pin <= next_frame_start_pin;
         eight_meg_clock_out <= next_eight_meg_clock_out;
      end
   end
endmodule // tsm_test_signal_output_mux

// ---- design/tsm_regs.vh ----
// Register offsets, field positions, reset values and selector codes for the test output mux.
`ifndef TSM_REGS_VH
`define TSM_REGS_VH
`define TSM_PIN_CONFIG_OFFSET 12'h000
`define TSM_STATUS_OFFSET 12'h004
`define TSM_FIRST_SEL_LSB 0
`define TSM_SECOND_SEL_LSB 8
`define TSM_SEL_WIDTH 5
`define TSM_PIN_CONFIG_RESET 32'h00000000
`define TSM_SEL_NORMAL 5'h00
`define TSM_SEL_ADC_LSB 5'h01
`define TSM_SEL_PULSE 5'h02
`define TSM_SEL_LOCK 5'h03
`define TSM_SEL_MOD_A 5'h04
`define TSM_SEL_MOD_B 5'h05
`define TSM_SEL_PD_SYNTH 5'h06
`define TSM_SEL_PD_CONV 5'h07
`define TSM_SEL_PD_VGA 5'h08
`define TSM_SEL_PD_BPF 5'h09
`define TSM_SEL_PD_LNA 5'h0A
`define TSM_SEL_PD_PA 5'h0B
`define TSM_SEL_12 5'h0C
`define TSM_SEL_13 5'h0D
`define TSM_SEL_14 5'h0E
`define TSM_SEL_GAINMODE 5'h0F
`define TSM_SEL_VGA_GAIN 5'h10
`define TSM_SEL_17 5'h11
`define TSM_SEL_23 5'h17
`define TSM_SEL_24 5'h18
`define TSM_SEL_REF 5'h19
`define TSM_SEL_DIV 5'h1A
`define TSM_SEL_WIN 5'h1B
`define TSM_SEL_WIN_SYNC 5'h1C
`define TSM_SEL_CONV_CLK 5'h1D
`define TSM_SEL_ZERO 5'h1E
`define TSM_SEL_ONE 5'h1F
`endif

// ---- bench/tsm_pin_probe.sv ----
// Observer standing in for the test equipment that watches both status pins.
`timescale 1ns/1ps
module tsm_pin_probe (
   input wire pclk,
   input wire a,
   input wire b,
   output logic [1:0] seen
);
   // It samples on the edge like a logic analyser and never drives the device.
   always @(posedge pclk) seen <= {b, a};
endmodule // tsm_pin_probe

// ---- bench/tsm_mux_checker.sv ----
// Checker for the mux pins; selects are tracked from completed APB writes.
`timescale 1ns/1ps
module tsm_mux_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire channel_clear_in,
   input wire frame_start_in,
   input wire demod_late_pulse,
   input wire demod_early_pulse,
   input wire gain_change_pulse,
   input wire channel_clear_pin,
   input wire frame_start_pin,
   input wire eight_meg_clock_out
);
   logic [4:0] s1, s2;
   // Selects land at the handshake edge; only idle cycles are judged to keep bus timing out.
   wire idle = !(psel && penable);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= 5'h00;
         s2 <= 5'h00;
      end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
         s1 <= pwdata[4:0];
         s2 <= pwdata[12:8];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_first_normal: assert property (
      idle && s1 == 5'h00 |=> channel_clear_pin == $past(channel_clear_in)) else $error("pin1");
   chk_second_normal: assert property (
      idle && s2 == 5'h00 |=> frame_start_pin == $past(frame_start_in)) else $error("pin2");
   chk_late_pulse: assert property (
      idle && s1 == 5'h02 |=> channel_clear_pin == $past(demod_late_pulse)) else $error("late");
   chk_early_pulse: assert property (
      idle && s2 == 5'h02 |=> frame_start_pin == $past(demod_early_pulse)) else $error("early");
   chk_gain_pulse: assert property (
      idle && s1 == 5'h0C |=> channel_clear_pin == $past(gain_change_pulse)) else $error("gain");
   chk_reserved_low: assert property (
      idle && s1 >= 5'h12 && s1 <= 5'h16 |=> !channel_clear_pin) else $error("reserved");
   chk_const_high: assert property (
      idle && s2 == 5'h1F |=> frame_start_pin) else $error("high");
   chk_eight_meg_gate: assert property (
      idle && s1 != 5'h17 |=> !eight_meg_clock_out) else $error("clock out");
endmodule // tsm_mux_checker
bind tsm_test_signal_output_mux tsm_mux_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .channel_clear_in, .frame_start_in, .demod_late_pulse,
   .demod_early_pulse, .gain_change_pulse, .channel_clear_pin, .frame_start_pin,
   .eight_meg_clock_out);

// ---- bench/tsm_test_signal_output_mux_tb.sv ----
// Self-checking bench for the test signal output mux.
`timescale 1ns/1ps
module tsm_test_signal_output_mux_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, ccp, fsp, m8;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic [39:0] src = 40'h8000000000, v;
   logic [1:0] seen;
   int n_fail = 0, comparisons = 0, cycles = 0;
   // Source bit per select; bit 38 stays low and bit 39 high for constants and reserved codes.
   byte m1[32] = '{0,2,4,7,8,9,12,13,14,15,16,17,6,19,21,24,26,27,
      38,38,38,38,38,29,30,31,32,33,34,36,38,39};
   byte m2[32] = '{1,3,5,7,10,11,12,13,14,15,16,17,18,20,22,23,25,28,
      38,38,38,38,38,38,35,31,32,33,34,37,38,39};
   tsm_test_signal_output_mux dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .channel_clear_in(src[0]), .frame_start_in(src[1]),
      .adc_q_lsb(src[2]), .adc_i_lsb(src[3]), .demod_late_pulse(src[4]),
      .demod_early_pulse(src[5]), .gain_change_pulse(src[6]), .synth_lock_flag(src[7]),
      .modulator_chip_rate_clock(src[8]), .modulator_bit_rate_clock(src[9]),
      .modulator_chip_stream(src[10]), .modulator_bit_stream(src[11]),
      .power_down_controls(src[17:12]), .vga_peak_detect(src[22:18]),
      .frontend_gain_mode(src[24:23]), .vga_gain(src[26:25]), .peak_reset_n(src[27]),
      .rx_filter_calibration_clock(src[28]), .eight_meg_clock_in(src[29]),
      .crystal_stable_flag(src[30]), .synth_reference_signal(src[31]),
      .synth_divided_signal(src[32]), .synth_lock_window(src[33]),
      .synth_lock_window_sync(src[34]), .synth_freq_comparator_out(src[35]),
      .converter_clock_one(src[36]), .converter_clock_two(src[37]),
      .channel_clear_pin(ccp), .frame_start_pin(fsp), .eight_meg_clock_out(m8));
   tsm_pin_probe probe (.pclk, .a(ccp), .b(fsp), .seen);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task final_report;
      if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial forever #50 pclk = ~pclk;
   // The whole run needs well under a thousand cycles; this only cuts a hang short.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         final_report;
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h00000000);
      chk(q, 32'h00000000);
      for (int s = 0; s < 32; s++) begin
         apb(1'b1, 12'h000, {19'h0, s[4:0], 3'h0, s[4:0]});
         apb(1'b0, 12'h000, 32'h00000000);
         chk(q, {19'h0, s[4:0], 3'h0, s[4:0]});
         for (int p = 0; p < 2; p++) begin
            @(posedge pclk);
            v = (40'h0000000001 << m1[s]) | (40'h0000000001 << m2[s]);
            if (p == 1) v = ~v;
            v[38] = 1'b0;
            v[39] = 1'b1;
            src <= v;
            repeat (2) @(posedge pclk);
            #1;
            chk({m8, seen}, {s == 23 && v[29], v[m2[s]], v[m1[s]]});
         end
      end
      apb(1'b0, 12'h004, 32'h00000000);
      chk(q, 32'h0000000F);
      apb(1'b0, 12'h008, 32'h00000000);
      chk({31'h0, e}, 32'h00000001);
      final_report;
   end
endmodule // tsm_test_signal_output_mux_tb
